// [hw/scru_core.sv]
// Subroutine call and return sequencer with its register port.
module scru_core (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Memory bus.
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_opfetch,
    // Other opcode passed over.
    output logic foreign_opcode
);
    import scru_pkg::*;

    scru_timer_if tif ();

    scru_state_type state;
    scru_state_type next_state;
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [7:0] flags;
    logic ctrl_run;
    logic [7:0] opcode;
    logic is_call;
    logic is_ret;
    logic call_taken;
    logic [7:0] target_lo;
    logic [7:0] target_hi;
    logic [15:0] next_addr;
    logic [15:0] pc_inc;
    logic adv;
    logic fetch_end;
    logic ins_end;
    logic op_is_call;
    logic op_is_cond_call;
    logic op_is_ret;
    logic op_taken;
    logic [4:0] ins_t;
    logic [15:0] instr_addr;
    logic [15:0] sp_start;
    logic sel_flag;
    logic cond_expect;

    function automatic logic cond_met(input logic [2:0] cc,
                                      input logic [7:0] f);
        logic r;
        r = 1'b0;
        unique case (cc)
            CC_NOT_ZERO: r = !f[FLAG_ZERO];
            CC_ZERO: r = f[FLAG_ZERO];
            CC_NO_CARRY: r = !f[FLAG_CARRY];
            CC_CARRY: r = f[FLAG_CARRY];
            CC_PARITY_ODD: r = !f[FLAG_PARITY];
            CC_PARITY_EVEN: r = f[FLAG_PARITY];
            CC_SIGN_POS: r = !f[FLAG_SIGN];
            CC_SIGN_NEG: r = f[FLAG_SIGN];
        endcase
        return r;
    endfunction

    scru_mcycle_timer u_timer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .tif(tif.timer)
    );

    // Decoding of the byte read in the opcode fetch.
    assign op_is_cond_call =
        (mem_rdata & COND_CALL_MASK) == COND_CALL_PAT;
    assign op_is_call = (mem_rdata == OPC_CALL) || op_is_cond_call;
    assign op_is_ret = mem_rdata == OPC_RET;
    assign op_taken = (mem_rdata == OPC_CALL)
                      || cond_met(mem_rdata[5:3], flags);
    assign pc_inc = program_counter + 16'h0001;

    // Machine cycle length for each state.
    always_comb begin
        tif.active = state != ST_HALT;
        unique case (state)
            ST_HALT: tif.len = T_FETCH;
            ST_FETCH: tif.len = T_FETCH;
            ST_RDL: tif.len = T_READ;
            ST_RDH: tif.len = call_taken ? T_OPH_CALL : T_READ;
            ST_PUSHH: tif.len = T_WRITE;
            ST_PUSHL: tif.len = T_WRITE;
            default: tif.len = T_FETCH;
        endcase
    end

    // Memory data is taken on the last state of each read cycle.
    assign adv = ce && ((state == ST_HALT) || tif.last);
    assign fetch_end = ce && (state == ST_FETCH) && tif.last;
    assign ins_end = ce && tif.last && (state != ST_HALT)
                     && ((next_state == ST_FETCH) || (next_state == ST_HALT));

    // Next state and next bus address.
    always_comb begin
        next_state = state;
        next_addr = mem_addr;
        unique case (state)
            ST_HALT: begin
                next_state = ctrl_run ? ST_FETCH : ST_HALT;
                next_addr = program_counter;
            end
            ST_FETCH: begin
                if (op_is_call) begin
                    next_state = ST_RDL;
                    next_addr = pc_inc;
                end else if (op_is_ret) begin
                    next_state = ST_RDL;
                    next_addr = stack_pointer;
                end else begin
                    next_state = ctrl_run ? ST_FETCH : ST_HALT;
                    next_addr = pc_inc;
                end
            end
            ST_RDL: begin
                next_state = ST_RDH;
                next_addr = is_call ? pc_inc
                                    : stack_pointer + 16'h0001;
            end
            ST_RDH: begin
                if (is_call && call_taken) begin
                    next_state = ST_PUSHH;
                    next_addr = stack_pointer - 16'h0001;
                end else begin
                    next_state = ctrl_run ? ST_FETCH : ST_HALT;
                    next_addr = is_call ? pc_inc
                                        : {mem_rdata, target_lo};
                end
            end
            ST_PUSHH: begin
                next_state = ST_PUSHL;
                next_addr = stack_pointer - 16'h0001;
            end
            ST_PUSHL: begin
                next_state = ctrl_run ? ST_FETCH : ST_HALT;
                next_addr = {target_hi, target_lo};
            end
            default: begin
                next_state = ST_HALT;
                next_addr = program_counter;
            end
        endcase
    end

    // Sequencer state.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= ST_HALT;
        end else if (adv) begin
            state <= next_state;
        end
    end

    // Decoded instruction held for its remaining machine cycles.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            opcode <= 8'h00;
            is_call <= 1'b0;
            is_ret <= 1'b0;
            call_taken <= 1'b0;
        end else if (fetch_end) begin
            opcode <= mem_rdata;
            is_call <= op_is_call;
            is_ret <= op_is_ret;
            call_taken <= op_is_call && op_taken;
        end
    end

    // Target and popped bytes.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            target_lo <= 8'h00;
            target_hi <= 8'h00;
        end else if (adv && (state == ST_RDL)) begin
            target_lo <= mem_rdata;
        end else if (adv && (state == ST_RDH)) begin
            target_hi <= mem_rdata;
        end
    end

    // Program counter.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            program_counter <= PC_RESET;
        end else if (ce) begin
            if (state == ST_HALT) begin
                if (reg_wr && (reg_addr == REG_PC)) begin
                    program_counter <= reg_wdata[15:0];
                end
            end else if (tif.last) begin
                unique case (state)
                    ST_FETCH: program_counter <= pc_inc;
                    ST_RDL: begin
                        if (is_call) begin
                            program_counter <= pc_inc;
                        end
                    end
                    ST_RDH: begin
                        if (is_call) begin
                            program_counter <= pc_inc;
                        end else begin
                            program_counter <= {mem_rdata, target_lo};
                        end
                    end
                    ST_PUSHL:
                        program_counter <= {target_hi, target_lo};
                    default: program_counter <= program_counter;
                endcase
            end
        end
    end

    // Stack pointer.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stack_pointer <= SP_RESET;
        end else if (ce) begin
            if (state == ST_HALT) begin
                if (reg_wr && (reg_addr == REG_SP)) begin
                    stack_pointer <= reg_wdata[15:0];
                end
            end else if (tif.last) begin
                if ((state == ST_RDL) && is_ret) begin
                    stack_pointer <= stack_pointer + 16'h0001;
                end else if ((state == ST_RDH) && is_ret) begin
                    stack_pointer <= stack_pointer + 16'h0001;
                end else if ((state == ST_RDH) && call_taken) begin
                    stack_pointer <= stack_pointer - 16'h0001;
                end else if (state == ST_PUSHH) begin
                    stack_pointer <= stack_pointer - 16'h0001;
                end
            end
        end
    end

    // Memory bus address, write data and passed-over opcode pulse.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mem_addr <= PC_RESET;
            mem_wdata <= 8'h00;
            foreign_opcode <= 1'b0;
        end else if (ce) begin
            foreign_opcode <= fetch_end && !op_is_call && !op_is_ret;
            if (adv) begin
                mem_addr <= next_addr;
                if (state == ST_RDH) begin
                    mem_wdata <= pc_inc[15:8];
                end else if (state == ST_PUSHH) begin
                    mem_wdata <= program_counter[7:0];
                end
            end
        end
    end

    assign mem_rd = (state == ST_FETCH) || (state == ST_RDL)
                    || (state == ST_RDH);
    assign mem_wr = (state == ST_PUSHH) || (state == ST_PUSHL);
    assign mem_opfetch = state == ST_FETCH;

    // Software registers; the flag register is only written by software.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flags <= FLAGS_RESET;
            ctrl_run <= CTRL_RUN_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == REG_FLAGS) begin
                flags <= reg_wdata[7:0];
            end
            if (reg_addr == REG_CTRL) begin
                ctrl_run <= reg_wdata[CTRL_RUN_BIT];
            end
        end
    end

    // Read data stands for one cycle after the read strobe.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_PC: reg_rdata <= {16'h0000, program_counter};
                    REG_SP: reg_rdata <= {16'h0000, stack_pointer};
                    REG_FLAGS: reg_rdata <= {24'h000000, flags};
                    REG_CTRL: reg_rdata <= {31'h00000000, ctrl_run};
                    REG_STATUS: reg_rdata <= {15'h0000, state != ST_HALT,
                        opcode, 3'h0, is_ret, call_taken, state};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Helper logic for the checks below.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ins_t <= 5'h01;
            instr_addr <= PC_RESET;
            sp_start <= SP_RESET;
        end else if (ce) begin
            if ((state == ST_HALT) || ins_end) begin
                ins_t <= 5'h01;
            end else begin
                ins_t <= ins_t + 5'h01;
            end
            if (fetch_end) begin
                instr_addr <= program_counter;
                sp_start <= stack_pointer;
            end
        end
    end

    always_comb begin
        unique case (mem_rdata[5:4])
            2'h0: sel_flag = flags[FLAG_ZERO];
            2'h1: sel_flag = flags[FLAG_CARRY];
            2'h2: sel_flag = flags[FLAG_PARITY];
            2'h3: sel_flag = flags[FLAG_SIGN];
        endcase
    end
    assign cond_expect = sel_flag == mem_rdata[3];

    AST_CALL_DECODE: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fetch_end && mem_rdata == OPC_CALL)
        |=> (state == ST_RDL && is_call && call_taken && mem_rd))
        else $error("Call opcode not decoded.");

    AST_PUSH_HIGH: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (state == ST_PUSHH) |-> (mem_wr && mem_addr == stack_pointer
        && stack_pointer == sp_start - 16'h0001
        && mem_wdata == program_counter[15:8]))
        else $error("High byte push wrong.");

    AST_PUSH_LOW: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (state == ST_PUSHL) |-> (mem_wr && mem_addr == stack_pointer
        && stack_pointer == sp_start - 16'h0002
        && mem_wdata == program_counter[7:0]))
        else $error("Low byte push wrong.");

    AST_RETURN_ADDR: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (state == ST_PUSHH) |-> (program_counter == instr_addr + INSTR_LEN))
        else $error("Pushed address is not opcode plus three.");

    AST_CALL_TARGET: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ce && state == ST_PUSHL && tif.last)
        |=> (program_counter == {target_hi, target_lo}
        && mem_addr == program_counter))
        else $error("Call target not loaded.");

    AST_CALL_TIME: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ins_end && state == ST_PUSHL) |-> (ins_t == CALL_T_TOTAL))
        else $error("Taken call is not 17 states.");

    AST_CALL_SKIP: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ins_end && state == ST_RDH && is_call)
        |=> (!mem_wr && program_counter == instr_addr + INSTR_LEN
        && stack_pointer == sp_start))
        else $error("Skipped call changed stack or target.");

    AST_SKIP_TIME: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ins_end && state == ST_RDH && is_call) |-> (ins_t == SKIP_T_TOTAL))
        else $error("Skipped call is not 10 states.");

    AST_COND_EVAL: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fetch_end && mem_rdata[7:6] == 2'h3 && mem_rdata[2:0] == 3'h4)
        |=> (call_taken == $past(cond_expect)))
        else $error("Condition evaluated wrongly.");

    AST_RET_POP: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (state == ST_RDH && is_ret) |-> (mem_rd
        && mem_addr == stack_pointer
        && stack_pointer == sp_start + 16'h0001))
        else $error("Return high byte read from wrong place.");

    AST_RET_END: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ins_end && state == ST_RDH && is_ret)
        |=> (stack_pointer == sp_start + 16'h0002
        && program_counter == {$past(mem_rdata), target_lo}))
        else $error("Return left stack or counter wrong.");

    AST_RET_TIME: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (ins_end && state == ST_RDH && is_ret) |-> (ins_t == RET_T_TOTAL))
        else $error("Return is not 10 states.");

    AST_FLAGS_KEPT: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !(ce && reg_wr && reg_addr == REG_FLAGS) |=> $stable(flags))
        else $error("Flags changed without a write.");

    AST_COND_DECODE: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fetch_end && mem_rdata[7:6] == 2'h3 && mem_rdata[2:0] == 3'h4)
        |=> (state == ST_RDL && is_call))
        else $error("Conditional call not decoded.");

endmodule

// [hw/scru_mcycle_timer.sv]
// Clock state counter for one machine cycle of programmable length.
module scru_mcycle_timer (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Timing to the sequencer.
    scru_timer_if.timer tif
);
    import scru_pkg::*;

    // Counts clock states from one; the last one ends the machine cycle.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tif.t_state <= 3'h1;
        end else if (ce) begin
            if (!tif.active || tif.last) begin
                tif.t_state <= 3'h1;
            end else begin
                tif.t_state <= tif.t_state + 3'h1;
            end
        end
    end

    assign tif.last = tif.active && (tif.t_state == tif.len);

endmodule

// [hw/scru_pkg.sv]
// Constants and types shared by the subroutine call and return unit.
package scru_pkg;

    // Opcodes and the conditional call pattern.
    localparam logic [7:0] OPC_CALL = 8'hcd;
    localparam logic [7:0] OPC_RET = 8'hc9;
    localparam logic [7:0] COND_CALL_MASK = 8'hc7;
    localparam logic [7:0] COND_CALL_PAT = 8'hc4;

    // Condition codes.
    localparam logic [2:0] CC_NOT_ZERO = 3'h0;
    localparam logic [2:0] CC_ZERO = 3'h1;
    localparam logic [2:0] CC_NO_CARRY = 3'h2;
    localparam logic [2:0] CC_CARRY = 3'h3;
    localparam logic [2:0] CC_PARITY_ODD = 3'h4;
    localparam logic [2:0] CC_PARITY_EVEN = 3'h5;
    localparam logic [2:0] CC_SIGN_POS = 3'h6;
    localparam logic [2:0] CC_SIGN_NEG = 3'h7;

    // Bit positions inside the flag register.
    localparam int FLAG_SIGN = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_CARRY = 0;

    // Clock states per machine cycle and per instruction, and the call length in bytes.
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_READ = 3'h3;
    localparam logic [2:0] T_OPH_CALL = 3'h4;
    localparam logic [2:0] T_WRITE = 3'h3;
    localparam logic [4:0] CALL_T_TOTAL = 5'h11;
    localparam logic [4:0] SKIP_T_TOTAL = 5'h0a;
    localparam logic [4:0] RET_T_TOTAL = 5'h0a;
    localparam logic [15:0] INSTR_LEN = 16'h0003;

    // Register offsets, control bits and reset values.
    localparam logic [7:0] REG_PC = 8'h00;
    localparam logic [7:0] REG_SP = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic CTRL_RUN_RESET = 1'b0;

    // Sequencer states, Gray coded along the call path.
    typedef enum logic [2:0] {
        ST_HALT = 3'h0,
        ST_FETCH = 3'h1,
        ST_RDL = 3'h3,
        ST_RDH = 3'h2,
        ST_PUSHH = 3'h6,
        ST_PUSHL = 3'h7
    } scru_state_type;

endpackage

// [hw/scru_timer_if.sv]
// Machine cycle timing signals between the sequencer and its timer.
interface scru_timer_if;
    logic active;
    logic [2:0] len;
    logic [2:0] t_state;
    logic last;
    modport timer (input active, input len, output t_state, output last);
    modport seq (output active, output len, input t_state, input last);
endinterface

// [test/scru_mem_model.sv]
// Behavioural program and stack memory facing the unit's memory bus.
module scru_mem_model (
    // Clock.
    input wire logic clk_sys,
    // Memory bus.
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last;

    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        last = 8'h00;
    end

    // Stores the presented byte during a write cycle.
    always @(posedge clk_sys) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            last <= mem[mem_addr];
        end
    end

    // Returns the addressed byte while reading, else a stale inverse.
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
endmodule

// [test/tb_subroutine_call_return_unit.sv]
// Self-checking bench for the subroutine call and return unit.
module tb_subroutine_call_return_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import scru_pkg::*;
    logic clk_sys, rstn, ce, reg_wr, reg_rd, mem_rd, mem_wr, mem_opfetch;
    logic foreign_opcode;
    int fo[$];
    logic [7:0] reg_addr, mem_wdata, mem_rdata;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [15:0] mem_addr, prev_addr;
    logic prev_f, prev_w;
    logic [15:0] fa[$];
    int fc[$];
    logic [23:0] wl[$];
    int cyc, failures, samples_checked, k, w;

    scru_core i_scru_core (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_opfetch(mem_opfetch),
        .foreign_opcode(foreign_opcode));
    scru_mem_model i_scru_mem_model (.clk_sys(clk_sys),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Logs the start of every opcode fetch and every stack write.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (mem_opfetch && !(prev_f && mem_addr == prev_addr)) begin
            fa.push_back(mem_addr);
            fc.push_back(cyc);
        end
        if (mem_wr && !(prev_w && mem_addr == prev_addr)) begin
            wl.push_back({mem_addr, mem_wdata});
        end
        if (foreign_opcode) begin
            fo.push_back(cyc);
        end
        prev_f <= mem_opfetch;
        prev_w <= mem_wr;
        prev_addr <= mem_addr;
        if (cyc == 20000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic exp_fetch(input logic [15:0] a, input int delta);
        chk({16'h0000, fa[k]}, {16'h0000, a});
        if (k > 0) begin
            chk(fc[k] - fc[k-1], delta);
        end
        k = k + 1;
    endtask

    task automatic exp_push(input logic [15:0] ra);
        chk({8'h00, wl[w]}, {8'h00, 16'h3001, ra[15:8]});
        chk({8'h00, wl[w+1]}, {8'h00, 16'h3000, ra[7:0]});
        w = w + 2;
    endtask

    function automatic logic taken(input logic [2:0] cc, input logic [7:0] f);
        case (cc)
            3'h0: return !f[FLAG_ZERO];
            3'h1: return f[FLAG_ZERO];
            3'h2: return !f[FLAG_CARRY];
            3'h3: return f[FLAG_CARRY];
            3'h4: return !f[FLAG_PARITY];
            3'h5: return f[FLAG_PARITY];
            3'h6: return !f[FLAG_SIGN];
            default: return f[FLAG_SIGN];
        endcase
    endfunction

    // Call, return, then all eight conditional calls under given flags.
    task automatic run_prog(input logic [7:0] flags);
        logic [15:0] a;
        reg_write(REG_PC, 32'h00001a47);
        reg_write(REG_SP, 32'h00003002);
        reg_write(REG_FLAGS, {24'h000000, flags});
        fa.delete();
        fc.delete();
        wl.delete();
        fo.delete();
        k = 0;
        w = 0;
        reg_write(REG_CTRL, 32'h00000001);
        repeat (300) @(posedge clk_sys);
        reg_write(REG_CTRL, 32'h00000000);
        repeat (20) @(posedge clk_sys);
        exp_fetch(16'h1a47, 0);
        exp_fetch(16'h2135, 17);
        exp_push(16'h1a4a);
        exp_fetch(16'h1a4a, 10);
        for (int cc = 0; cc < 8; cc++) begin
            a = 16'h1a4a + 16'(3 * cc);
            if (taken(3'(cc), flags)) begin
                exp_fetch(16'h2135, 17);
                exp_push(a + 16'h0003);
                exp_fetch(a + 16'h0003, 10);
            end else begin
                exp_fetch(a + 16'h0003, 10);
            end
        end
        chk(fo[0] - fc[k-1], 4);
        reg_read(REG_SP);
        chk(rd_val, 32'h00003002);
        reg_read(REG_FLAGS);
        chk(rd_val, {24'h000000, flags});
    endtask

    // A write while the clock enable is low must leave the flags alone.
    task automatic ce_hold();
        @(posedge clk_sys);
        ce <= 1'b0;
        reg_write(REG_FLAGS, 32'h000000ff);
        ce <= 1'b1;
        reg_read(REG_FLAGS);
        chk(rd_val, {24'h000000, FLAGS_RESET});
    endtask

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        prev_f = 1'b0;
        prev_w = 1'b0;
        prev_addr = 16'h0000;
        cyc = 0;
        failures = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_read(REG_PC);
        chk(rd_val, {16'h0000, PC_RESET});
        reg_read(REG_SP);
        chk(rd_val, {16'h0000, SP_RESET});
        reg_read(REG_FLAGS);
        chk(rd_val, {24'h000000, FLAGS_RESET});
        reg_read(8'h20);
        chk(rd_val, 32'h00000000);
        ce_hold();
        i_scru_mem_model.mem[16'h1a47] = OPC_CALL;
        i_scru_mem_model.mem[16'h1a48] = 8'h35;
        i_scru_mem_model.mem[16'h1a49] = 8'h21;
        i_scru_mem_model.mem[16'h2135] = OPC_RET;
        for (int cc = 0; cc < 8; cc++) begin
            i_scru_mem_model.mem[16'h1a4a + 3 * cc] = {2'b11, 3'(cc), 3'h4};
            i_scru_mem_model.mem[16'h1a4b + 3 * cc] = 8'h35;
            i_scru_mem_model.mem[16'h1a4c + 3 * cc] = 8'h21;
        end
        run_prog(8'h00);
        run_prog(8'hc5);
        wrap_up();
    end
endmodule
